// ### cal_window_pkg.sv
package cal_window_pkg;
  // special-function register addresses
  localparam logic [7:0] ADDR_CALIBRATION_POINTER       = 8'hBA;
  localparam logic [7:0] ADDR_CALIBRATION_COEFFICIENT   = 8'hBB;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL         = 8'hE8;
  localparam logic [7:0] ADDR_GREATER_THAN_LIMIT_LOW    = 8'hC4;
  localparam logic [7:0] ADDR_GREATER_THAN_LIMIT_HIGH   = 8'hC5;
  localparam logic [7:0] ADDR_LESS_THAN_LIMIT_LOW       = 8'hC6;
  localparam logic [7:0] ADDR_LESS_THAN_LIMIT_HIGH      = 8'hC7;
  // pointer fields
  localparam int         PTR_POINTER_AUTO_INCREMENT_BIT   = 7;
  localparam int         PTR_SEL_BIT    = 6;
  localparam int         PTR_LOC_W      = 6;
  localparam logic [7:0] POINTER_RESET  = 8'hD7;
  // converter control fields
  localparam int         CTL_WINT_BIT   = 5;
  localparam int         CTL_DIFF_BIT   = 0;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  // coefficient space
  localparam int         COEF_DEPTH     = 64;
  localparam logic [5:0] LOC_LIN_LAST   = 6'h12;
  localparam logic [5:0] LOC_OFFSET_LO  = 6'h13;
  localparam logic [5:0] LOC_OFFSET_HI  = 6'h14;
  localparam logic [5:0] LOC_GAIN_LO    = 6'h15;
  localparam logic [5:0] LOC_GAIN_HI    = 6'h16;
  localparam logic [7:0] OFFSET_HI_MASK = 8'h3F;
  localparam logic [7:0] GAIN_HI_MASK   = 8'h1F;
  localparam logic [7:0] LIMIT_RESET    = 8'h00;
endpackage

// ### adc_cal_access_and_window_detect.sv
`timescale 1ns/10ps
`default_nettype none
module adc_cal_access_and_window_detect (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_first_converter_data,
  output logic             o_window_compare_flag
);
  logic [7:0]  calibration_pointer;
  logic [7:0]  converter_control;
  logic [7:0]  greater_than_limit_high;
  logic [7:0]  greater_than_limit_low;
  logic [7:0]  less_than_limit_high;
  logic [7:0]  less_than_limit_low;
  logic [7:0]  coef_mem [0:2*cal_window_pkg::COEF_DEPTH-1];
  logic [7:0]  rdata;
  logic [7:0]  next_pointer;
  logic [7:0]  next_control;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire         sel_ptr  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_CALIBRATION_POINTER);
  wire         sel_coef = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_CALIBRATION_COEFFICIENT);
  wire         sel_ctl  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_CONVERTER_CONTROL);
  wire         sel_gtl  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_GREATER_THAN_LIMIT_LOW);
  wire         sel_gth  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_GREATER_THAN_LIMIT_HIGH);
  wire         sel_ltl  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_LESS_THAN_LIMIT_LOW);
  wire         sel_lth  = hit(i_sfr_addr,
                              cal_window_pkg::ADDR_LESS_THAN_LIMIT_HIGH);

  wire [5:0]   coefficient_location =
    calibration_pointer[cal_window_pkg::PTR_LOC_W-1:0];
  wire         converter_select =
    calibration_pointer[cal_window_pkg::PTR_SEL_BIT];
  wire         pointer_auto_increment =
    calibration_pointer[cal_window_pkg::PTR_POINTER_AUTO_INCREMENT_BIT];
  wire [6:0]   coef_index = {converter_select, coefficient_location};
  wire         coef_access = sel_coef & (i_sfr_wr | i_sfr_rd);
  wire [5:0]   next_location = coefficient_location + 6'h01;

  // unused upper bits of offset and gain high bytes store as zero
  wire [7:0]   coef_wmask =
    (coefficient_location == cal_window_pkg::LOC_OFFSET_HI) ?
      cal_window_pkg::OFFSET_HI_MASK :
    (coefficient_location == cal_window_pkg::LOC_GAIN_HI) ?
      cal_window_pkg::GAIN_HI_MASK : 8'hFF;

  wire         diff_mode = converter_control[cal_window_pkg::CTL_DIFF_BIT];
  wire [15:0]  gt_word = {greater_than_limit_high,
                          greater_than_limit_low};
  wire [15:0]  lt_word = {less_than_limit_high, less_than_limit_low};
  // first converter data holds the differential word in diff mode
  wire [15:0]  sample = i_first_converter_data;
  // signed compare via msb flip in differential mode
  wire [15:0]  s_cmp  = {sample[15] ^ diff_mode, sample[14:0]};
  wire [15:0]  gt_cmp = {gt_word[15] ^ diff_mode, gt_word[14:0]};
  wire [15:0]  lt_cmp = {lt_word[15] ^ diff_mode, lt_word[14:0]};
  wire         above_gt = s_cmp > gt_cmp;
  wire         below_lt = s_cmp < lt_cmp;
  wire         inside_mode = gt_cmp < lt_cmp;
  wire         window_hit = inside_mode ? (above_gt & below_lt)
                                        : (above_gt | below_lt);
  wire         set_flag = i_conv_done & window_hit;

  // pointer write wins over a same-cycle increment
  always_comb begin
    next_pointer = calibration_pointer;
    if (i_sfr_wr && sel_ptr) begin
      next_pointer = i_sfr_wdata;
    end else if (coef_access && pointer_auto_increment) begin
      next_pointer[5:0] = next_location;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      calibration_pointer <= cal_window_pkg::POINTER_RESET;
    end else begin
      calibration_pointer <= next_pointer;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sfr_wr && sel_coef) begin
      coef_mem[coef_index] <= i_sfr_wdata & coef_wmask;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      greater_than_limit_high <= cal_window_pkg::LIMIT_RESET;
    end else if (i_sfr_wr && sel_gth) begin
      greater_than_limit_high <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      greater_than_limit_low <= cal_window_pkg::LIMIT_RESET;
    end else if (i_sfr_wr && sel_gtl) begin
      greater_than_limit_low <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      less_than_limit_high <= cal_window_pkg::LIMIT_RESET;
    end else if (i_sfr_wr && sel_lth) begin
      less_than_limit_high <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      less_than_limit_low <= cal_window_pkg::LIMIT_RESET;
    end else if (i_sfr_wr && sel_ltl) begin
      less_than_limit_low <= i_sfr_wdata;
    end
  end

  // set beats a same-cycle software clear
  always_comb begin
    next_control = converter_control;
    if (i_sfr_wr && sel_ctl) begin
      next_control = i_sfr_wdata;
    end
    if (set_flag) begin
      next_control[cal_window_pkg::CTL_WINT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      converter_control <= cal_window_pkg::CONTROL_RESET;
    end else begin
      converter_control <= next_control;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    case (i_sfr_addr)
      cal_window_pkg::ADDR_CALIBRATION_POINTER: begin
        rdata = calibration_pointer;
      end
      cal_window_pkg::ADDR_CALIBRATION_COEFFICIENT: begin
        rdata = coef_mem[coef_index];
      end
      cal_window_pkg::ADDR_CONVERTER_CONTROL: begin
        rdata = converter_control;
      end
      cal_window_pkg::ADDR_GREATER_THAN_LIMIT_HIGH: begin
        rdata = greater_than_limit_high;
      end
      cal_window_pkg::ADDR_GREATER_THAN_LIMIT_LOW: begin
        rdata = greater_than_limit_low;
      end
      cal_window_pkg::ADDR_LESS_THAN_LIMIT_HIGH: begin
        rdata = less_than_limit_high;
      end
      cal_window_pkg::ADDR_LESS_THAN_LIMIT_LOW: begin
        rdata = less_than_limit_low;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata;
    end
  end

  assign o_window_compare_flag =
    converter_control[cal_window_pkg::CTL_WINT_BIT];
endmodule
`default_nettype wire

// ### cal_window_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cal_window_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        i_conv_done,
  input wire logic [15:0] i_first_converter_data,
  input wire logic        o_window_compare_flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire clr = i_sfr_wr && i_sfr_addr == 8'hE8 && !i_sfr_wdata[5];
  wire rdp = i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'hBA;
  wire map = i_sfr_addr inside {8'hBA, 8'hBB, 8'hE8, [8'hC4:8'hC7]};
  reset_out_a: assert property ($past(i_rst) |-> o_sfr_rdata == 8'h00
    && !o_window_compare_flag) else $error("outputs not reset");
  readback_a: assert property (i_sfr_wr && i_sfr_addr inside {8'hBA,
    [8'hC4:8'hC7]} ##1 i_sfr_rd && !i_sfr_wr && $stable(i_sfr_addr)
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("bad readback");
  unmapped_a: assert property (i_sfr_rd && !map |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved");
  flag_hold_a: assert property (o_window_compare_flag && !clr |=>
    o_window_compare_flag) else $error("flag dropped");
  flag_clear_a: assert property (clr && !i_conv_done |=>
    !o_window_compare_flag) else $error("flag not cleared");
  flag_cause_a: assert property ($rose(o_window_compare_flag) |->
    $past(i_conv_done) || $past(i_sfr_wr && i_sfr_addr == 8'hE8))
    else $error("flag set without cause");
  ptr_pointer_auto_increment_a: assert property (rdp ##1 (i_sfr_rd && !i_sfr_wr &&
    i_sfr_addr == 8'hBB) ##1 rdp |=> o_sfr_rdata[5:0] == 6'($past(
    o_sfr_rdata[5:0], 2) + 6'($past(o_sfr_rdata[7], 2))))
    else $error("pointer step wrong");
endmodule
`default_nettype wire

// ### adc_cal_access_and_window_detect_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_cal_access_and_window_detect_tb;
  logic        i_ref_clk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0;
  logic        i_conv_done = 0, o_window_compare_flag;
  logic [7:0]  i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, d;
  logic [15:0] i_first_converter_data = 0, x, g, l;
  logic [31:0] seed = 32'h00006095;
  logic [7:0]  v [2][4];
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  adc_cal_access_and_window_detect uut (.i_ref_clk, .i_rst, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .i_conv_done,
    .i_first_converter_data, .o_window_compare_flag);
  always #50 i_ref_clk = ~i_ref_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  function logic win(logic [15:0] x, g, l, logic s);
    logic a, b, o;
    a = s ? $signed(x) > $signed(g) : x > g;
    b = s ? $signed(x) < $signed(l) : x < l;
    o = s ? $signed(g) < $signed(l) : g < l;
    return o ? a && b : a || b;
  endfunction
  task chk(logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(logic [7:0] a, w);
    i_sfr_addr = a; i_sfr_wdata = w; i_sfr_rd = 0; i_sfr_wr = 1;
    @(negedge i_ref_clk);
  endtask
  task rd(logic [7:0] a);
    i_sfr_addr = a; i_sfr_wr = 0; i_sfr_rd = 1;
    @(negedge i_ref_clk);
    d = o_sfr_rdata;
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_rst = 0;
    rd(8'hBA); chk(d, 8'hD7);
    rd(8'h00); chk(d, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(8'hBA, 8'h93 | 8'(s << 6));
      for (int i = 0; i < 4; i++) begin
        v[s][i] = 8'(rnd());
        wr(8'hBB, v[s][i]);
      end
    end
    rd(8'hBA); rd(8'hBB); rd(8'hBA); chk(d, 8'hD8);
    for (int s = 0; s < 2; s++) begin
      wr(8'hBA, 8'h93 | 8'(s << 6));
      for (int i = 0; i < 4; i++) begin
        rd(8'hBB);
        chk(d, v[s][i] & (i == 1 ? 8'h3F : i == 3 ? 8'h1F : 8'hFF));
      end
    end
    wr(8'hBA, 8'h15); rd(8'hBB); rd(8'hBB); chk(d, v[0][2]);
    rd(8'hBA); chk(d, 8'h15);
    $display("coefficient test done");
    for (int k = 0; k < 60; k++) begin
      g = 16'(rnd()); l = k % 3 ? 16'(rnd()) : g + 16'h0100;
      x = k % 4 == 0 ? g : k % 4 == 1 ? l - 16'h0001 : 16'(rnd());
      wr(8'hC4, g[7:0]); wr(8'hC5, g[15:8]); wr(8'hC6, l[7:0]);
      wr(8'hC7, l[15:8]); rd(8'hC7); chk(d, l[15:8]);
      wr(8'hE8, {7'h00, k >= 30});
      i_sfr_wr = 0; i_first_converter_data = x; i_conv_done = 1;
      @(negedge i_ref_clk) i_conv_done = 0;
      chk({7'h00, o_window_compare_flag}, {7'h00, win(x, g, l, k >= 30)});
      rd(8'hE8); chk(d[5], win(x, g, l, k >= 30));
    end
    $display("window test done");
    conclude();
  end
endmodule
bind adc_cal_access_and_window_detect cal_window_asserts u_chk (.i_ref_clk,
  .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
  .i_conv_done, .i_first_converter_data, .o_window_compare_flag);
`default_nettype wire
